// >>> bench/error_node_monitor.sv
// checker for the error record node, bound to the design's ports
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/1ps
module error_node_monitor (
   input wire logic                     sys_clk,
   input wire logic                     arst_n,
   input wire err_node_pkg::detect_type detect,
   input wire logic [31:0]              dataIn,
   input wire logic [31:0]              correctedData,
   input wire logic [31:0]              dataOut,
   input wire err_node_pkg::inband_type inband,
   input wire logic                     faultIrq,
   input wire logic                     recoveryIrq,
   input wire logic [31:0]              s_axi_wdata,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic                     s_axi_rvalid
);
   logic abortCause;
   logic recCause;
   logic clearHit;
   assign abortCause = detect.valid && (detect.kind >= err_node_pkg::ERR_UEO
      || (detect.kind == err_node_pkg::ERR_DE && detect.maybePropagated));
   assign recCause = detect.valid && (detect.kind != err_node_pkg::ERR_CE || detect.softFault);
   assign clearHit = s_axi_wvalid && s_axi_wready && s_axi_wdata[err_node_pkg::ST_V];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   property p_abort_cause;
      inband.abort |-> $past(abortCause);
   endproperty
   a_abort_cause: assert property (p_abort_cause)
      else $error("abort without uncorrected cause");
   property p_abort_syn;
      inband.abort |-> inband.syndrome == $past(detect.syndrome);
   endproperty
   a_abort_syn: assert property (p_abort_syn)
      else $error("abort syndrome differs from detection");
   property p_ce_quiet;
      detect.valid && detect.kind == err_node_pkg::ERR_CE && !detect.softFault
         && !recoveryIrq |=> !recoveryIrq;
   endproperty
   a_ce_quiet: assert property (p_ce_quiet)
      else $error("corrected error raised recovery irq");
   property p_rec_cause;
      $rose(recoveryIrq) |-> $past(recCause);
   endproperty
   a_rec_cause: assert property (p_rec_cause)
      else $error("recovery irq without cause");
   property p_fault_cause;
      $rose(faultIrq) |-> $past(detect.valid);
   endproperty
   a_fault_cause: assert property (p_fault_cause)
      else $error("fault irq without detection");
   property p_irq_hold;
      $fell(faultIrq) || $fell(recoveryIrq) |-> $past(clearHit) || $past(clearHit, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without status clear");
   property p_data_pass;
      detect.valid |=> dataOut == ($past(detect.kind) == err_node_pkg::ERR_CE
         ? $past(correctedData) : $past(dataIn));
   endproperty
   a_data_pass: assert property (p_data_pass)
      else $error("wrong data passed to consumer");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
endmodule

bind error_record_node error_node_monitor i_error_node_monitor (.sys_clk, .arst_n, .detect,
   .dataIn, .correctedData, .dataOut, .inband, .faultIrq, .recoveryIrq, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// >>> bench/inband_consumer_model.sv
// consuming master: logs every in-band abort and the syndrome it carries
// assumes the abort is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
module inband_consumer_model (
   input  wire logic                     sys_clk,
   input  wire logic                     arst_n,
   input  wire err_node_pkg::inband_type inband,
   output int                            abortCount,
   output logic [15:0]                   lastSyndrome
);
   always @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         abortCount <= 0;
         lastSyndrome <= 16'h0000;
      end
      else if (inband.abort === 1'b1)
      begin
         abortCount <= abortCount + 1;
         lastSyndrome <= inband.syndrome;
      end
   end
endmodule

// >>> bench/testbench.sv
// self-checking bench: reference model of the record compared at every result
// assumes the package and the consumer model are compiled before it
`timescale 1ns/1ps
module testbench;
   logic                     sys_clk, arst_n, recovery_rst;
   err_node_pkg::detect_type detect;
   err_node_pkg::inband_type inband;
   logic [31:0]              dataIn, correctedData, dataOut, mSt, mAddr, ctl, rd;
   logic                     faultIrq, recoveryIrq, counterIrq, mFirq, mRirq;
   logic [31:0]              s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]               s_axi_wstrb;
   logic [1:0]               s_axi_bresp, s_axi_rresp, rs;
   logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                     s_axi_rvalid, s_axi_rready;
   logic [15:0]              lastSyndrome, mAbSyn;
   int                       mismatches, cmp_count, cyc, abortCount, mAbort, mCls, mCnt;
   logic [11:0] rAddr [5] = '{12'h000, 12'h008, 12'h040, 12'h048, 12'h100};
   logic [31:0] rExp [5] = '{err_node_pkg::FEATURE_VALUE, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000, 32'h0000_0000};
   logic [1:0]  rResp [5] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10};

   error_record_node i_error_record_node (.sys_clk, .arst_n, .recovery_rst, .detect, .dataIn,
      .correctedData, .dataOut, .inband, .faultIrq, .recoveryIrq, .counterIrq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   inband_consumer_model i_inband_consumer_model (.sys_clk, .arst_n, .inband, .abortCount,
      .lastSyndrome);

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task report_and_stop;
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // handshakes are judged at the falling edge, where ready and valid have settled
   task axiW(input logic [11:0] a, input logic [31:0] d);
      logic aT, wT, bT;
      @(posedge sys_clk);
      s_axi_awaddr <= {20'h0_0000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         aT = s_axi_awvalid && s_axi_awready;
         wT = s_axi_wvalid && s_axi_wready;
         bT = s_axi_bvalid === 1'b1;
         rs = s_axi_bresp;
         @(posedge sys_clk);
         if (aT)
            s_axi_awvalid <= 1'b0;
         if (wT)
            s_axi_wvalid <= 1'b0;
      end while (!bT);
      s_axi_bready <= 1'b0;
   endtask

   task axiR(input logic [11:0] a);
      logic aT, rT;
      @(posedge sys_clk);
      s_axi_araddr <= {20'h0_0000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge sys_clk);
         aT = s_axi_arvalid && s_axi_arready;
         rT = s_axi_rvalid === 1'b1;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge sys_clk);
         if (aT)
            s_axi_arvalid <= 1'b0;
      end while (!rT);
      s_axi_rready <= 1'b0;
   endtask

   task setCtl(input logic [31:0] v);
      ctl = v;
      axiW(err_node_pkg::OFF_CONTROL0, v);
   endtask

   task clr;
      axiW(err_node_pkg::OFF_STATUS0, 32'h4000_0000);
      {mSt, mCls, mFirq, mRirq} = '0;
   endtask

   task det(input int k, input logic mp, input logic wr, input logic sf);
      logic [15:0] sy;
      logic [31:0] ad, di, dc;
      int c;
      logic ov;
      sy = 16'($urandom);
      ad = $urandom;
      di = $urandom;
      dc = $urandom;
      c = (k == 2 && mp) ? 6 : k;
      @(posedge sys_clk);
      detect <= '{1'b1, err_node_pkg::err_class_type'(k[2:0]), mp, wr, sf, 1'b1, ad, sy,
                  $urandom};
      dataIn <= di;
      correctedData <= dc;
      @(posedge sys_clk);
      detect.valid <= 1'b0;
      #1 cmp("dataOut", (k == 1) ? dc : di, dataOut);
      if (ctl[0] && ctl[wr ? 9 : 8])
      begin
         mSt[30] = 1'b1;
         mSt[24] |= (c == 1);
         mSt[23] |= (c == 2);
         mSt[29] |= (c >= 3);
         if (c == 1)
            mCnt++;
         ov = (c == 1 && mCnt == 0);
         mSt[16] |= ov;
         mSt[27] |= ov || (c <= mCls && c != 1);
         if (c > mCls)
         begin
            mCls = c;
            mSt = {1'b1, mSt[30:23], c[2:0], mSt[19:16], sy};
            mSt[26] = 1'b1;
            mAddr = ad;
         end
         mFirq |= ctl[(c == 1) ? 3 : 4];
         mRirq |= ctl[2] && (c >= 3 || (c == 2 && ctl[5]) || sf);
         if (ctl[6] && c >= 3)
         begin
            mAbort++;
            mAbSyn = sy;
         end
      end
   endtask

   task chk;
      axiR(err_node_pkg::OFF_STATUS0);
      cmp("status", mSt, rd);
      axiR(err_node_pkg::OFF_ADDR0);
      if (mSt[31])
         cmp("faultAddr", mAddr, rd);
      cmp("faultIrq", {31'h0, mFirq}, {31'h0, faultIrq});
      cmp("recoveryIrq", {31'h0, mRirq}, {31'h0, recoveryIrq});
      cmp("counterIrq", {31'h0, mSt[16] & ctl[3]}, {31'h0, counterIrq});
      cmp("aborts", mAbort, abortCount);
      cmp("abortSyndrome", {16'h0, mAbSyn}, {16'h0, lastSyndrome});
   endtask

   initial
   begin
      {arst_n, recovery_rst, detect, dataIn, correctedData, s_axi_awaddr, s_axi_wdata} = '0;
      {s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      s_axi_rready = 1'b0;
      s_axi_wstrb = 4'hF;
      {mismatches, cmp_count, cyc, mAbort, mCls, mCnt, mSt, mAddr, ctl, mAbSyn} = '0;
      {mFirq, mRirq} = '0;
      void'($urandom(32'hd9be8ff0));
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      axiW(err_node_pkg::OFF_CONTROL1, 32'hFFFF_FFFF);
      cmp("writeResp", 32'h0000_0000, {30'h0, rs});
      for (int i = 0; i < 5; i++)
      begin
         axiR(rAddr[i]);
         cmp("readData", rExp[i], rd);
         cmp("readResp", {30'h0, rResp[i]}, {30'h0, rs});
      end
      det(4, 1'b0, 1'b0, 1'b0);
      chk();
      setCtl(err_node_pkg::CTL_MASK);
      for (int k = 1; k < 7; k++)
      begin
         clr();
         det(k, 1'b0, k[0], 1'b0);
         det(k, 1'b0, 1'b0, 1'b0);
         det((k > 1) ? k - 1 : 1, 1'b0, 1'b1, 1'b0);
         chk();
      end
      @(posedge sys_clk);
      recovery_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      recovery_rst <= 1'b0;
      chk();
      axiR(err_node_pkg::OFF_CONTROL0);
      cmp("control", ctl, rd);
      clr();
      det(2, 1'b1, 1'b0, 1'b0);
      chk();
      setCtl(32'h0000_035D);
      clr();
      det(2, 1'b0, 1'b0, 1'b0);
      chk();
      setCtl(32'h0000_017D);
      clr();
      det(5, 1'b0, 1'b1, 1'b0);
      det(3, 1'b0, 1'b0, 1'b0);
      chk();
      setCtl(32'h0000_0379);
      clr();
      det(6, 1'b0, 1'b0, 1'b0);
      setCtl(err_node_pkg::CTL_MASK);
      det(3, 1'b0, 1'b0, 1'b0);
      chk();
      for (int j = 0; j < 2; j++)
      begin
         setCtl(j ? 32'h0000_036D : 32'h0000_0375);
         clr();
         det(1, 1'b0, 1'b0, 1'b0);
         chk();
         det(4, 1'b0, 1'b0, 1'b0);
         chk();
      end
      setCtl(err_node_pkg::CTL_MASK);
      clr();
      axiW(err_node_pkg::OFF_MISC1, 32'hFFFF_FFFE);
      mCnt = -2;
      det(1, 1'b0, 1'b0, 1'b0);
      det(1, 1'b0, 1'b1, 1'b0);
      chk();
      axiR(err_node_pkg::OFF_MISC1);
      cmp("counter", 32'h0000_0000, rd);
      clr();
      det(1, 1'b0, 1'b0, 1'b1);
      chk();
      report_and_stop();
   end
endmodule

// >>> logic/err_node_pkg.sv
// package for the error record node: register map, fields, types
// assumes a 32-bit axi4-lite register bus and a single system clock
package err_node_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_FEATURE0 = 12'h000;
   localparam logic [11:0] OFF_CONTROL0 = 12'h008;
   localparam logic [11:0] OFF_STATUS0  = 12'h010;
   localparam logic [11:0] OFF_ADDR0    = 12'h018;
   localparam logic [11:0] OFF_MISC0    = 12'h020;
   localparam logic [11:0] OFF_MISC1    = 12'h028;
   localparam logic [11:0] OFF_FEATURE1 = 12'h040;
   localparam logic [11:0] OFF_CONTROL1 = 12'h048;
   // control bit positions
   localparam int CTL_ENABLE  = 0;
   localparam int CTL_UIRQ_EN = 2;
   localparam int CTL_CIRQ_EN = 3;
   localparam int CTL_FHI_EN  = 4;
   localparam int CTL_DEF_EN  = 5;
   localparam int CTL_INBAND  = 6;
   localparam int CTL_RD_EN   = 8;
   localparam int CTL_WR_EN   = 9;
   localparam logic [31:0] CTL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CTL_MASK    = 32'h0000_037D;
   // status bit positions
   localparam int ST_V   = 30;
   localparam int ST_UE  = 29;
   localparam int ST_OF  = 27;
   localparam int ST_MV  = 26;
   localparam int ST_AV  = 31;
   localparam int ST_CE  = 24;
   localparam int ST_DE  = 23;
   localparam int ST_UET = 20;
   localparam int ST_CNTOF = 16;
   // feature word: counter, split irq enables, deferred control, rd/wr split
   localparam logic [31:0] FEATURE_VALUE = 32'h0000_0A5D;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // error class, ordered by priority
   typedef enum logic [2:0] {
      ERR_NONE = 3'h0,
      ERR_CE   = 3'h1,
      ERR_DE   = 3'h2,
      ERR_UEO  = 3'h3,
      ERR_UER  = 3'h4,
      ERR_UEU  = 3'h5,
      ERR_UC   = 3'h6
   } err_class_type;
   // detection report from the datapath
   typedef struct packed {
      logic          valid;
      err_class_type kind;
      logic          maybePropagated;
      logic          isWrite;
      logic          softFault;
      logic          addrValid;
      logic [31:0]   addr;
      logic [15:0]   syndrome;
      logic [31:0]   unitInfo;
   } detect_type;
   // in-band answer to the consumer
   typedef struct packed {
      logic        abort;
      logic [15:0] syndrome;
   } inband_type;
endpackage

// >>> logic/error_record_node.sv
// error record node: records, classifies and reports detected errors
// assumes detection reports arrive on sys_clk; arst_n is power-on reset only,
// error-recovery reset (recovery_rst) leaves records intact
`timescale 1ns/1ps
module error_record_node (
   input  wire logic                      sys_clk,
   input  wire logic                      arst_n,
   input  wire logic                      recovery_rst,
   input  wire err_node_pkg::detect_type  detect,
   input  wire logic [31:0]               dataIn,
   input  wire logic [31:0]               correctedData,
   output logic [31:0]                    dataOut,
   output err_node_pkg::inband_type       inband,
   output logic                           faultIrq,
   output logic                           recoveryIrq,
   output logic                           counterIrq,
   input  wire logic [31:0]               s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [31:0]               s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);
   // record state
   logic [31:0]               ctl_q, ctl_d;
   logic [31:0]               addr_q, addr_d;
   logic [31:0]               misc0_q, misc0_d;
   logic [31:0]               misc1_q, misc1_d;
   logic [15:0]               syn_q, syn_d;
   err_node_pkg::err_class_type top_q, top_d;
   logic                      valid_q, valid_d;
   logic                      ceSeen_q, ceSeen_d;
   logic                      deSeen_q, deSeen_d;
   logic                      ueSeen_q, ueSeen_d;
   logic                      of_q, of_d;
   logic                      av_q, av_d;
   logic                      mv_q, mv_d;
   logic                      cntOf_q, cntOf_d;
   logic                      fhiPend_q, fhiPend_d;
   logic                      recPend_q, recPend_d;
   // consumer outputs
   logic [31:0]               dataOut_q, dataOut_d;
   err_node_pkg::inband_type  inband_q, inband_d;
   // bus state
   logic                      awHeld_q, awHeld_d;
   logic                      wHeld_q, wHeld_d;
   logic [11:0]               wAddr_q, wAddr_d;
   logic [31:0]               wData_q, wData_d;
   logic [3:0]                wStrb_q, wStrb_d;
   logic                      bValid_q, bValid_d;
   logic [1:0]                bResp_q, bResp_d;
   logic                      rValid_q, rValid_d;
   logic [31:0]               rData_q, rData_d;
   logic [1:0]                rResp_q, rResp_d;

   // derived detection terms
   err_node_pkg::err_class_type newKind;
   logic                      dirOk;
   logic                      logIt;
   logic                      isUe;
   logic                      doWrite;
   logic                      statusWr;
   logic [31:0]               statusRd;
   logic [31:0]               wMask;
   logic [31:0]               cntNext;

   always_comb
   begin
      // a deferred error (ERR_DE) that may have escaped is promoted to ERR_UC
      newKind = detect.kind;
      if (detect.maybePropagated && detect.kind == err_node_pkg::ERR_DE)
      begin
         newKind = err_node_pkg::ERR_UC;
      end
      dirOk = detect.isWrite ? ctl_q[err_node_pkg::CTL_WR_EN]
                             : ctl_q[err_node_pkg::CTL_RD_EN];
      logIt = detect.valid && ctl_q[err_node_pkg::CTL_ENABLE] && dirOk;
      isUe  = newKind >= err_node_pkg::ERR_UEO;
   end

   assign wMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign statusWr = doWrite && wAddr_q == err_node_pkg::OFF_STATUS0;

   always_comb
   begin
      statusRd = 32'h0000_0000;
      statusRd[err_node_pkg::ST_AV] = av_q;
      statusRd[err_node_pkg::ST_V] = valid_q;
      statusRd[err_node_pkg::ST_UE] = ueSeen_q;
      statusRd[err_node_pkg::ST_OF] = of_q;
      statusRd[err_node_pkg::ST_MV] = mv_q;
      statusRd[err_node_pkg::ST_CE] = ceSeen_q;
      statusRd[err_node_pkg::ST_DE] = deSeen_q;
      statusRd[err_node_pkg::ST_UET +: 3] = top_q;
      statusRd[err_node_pkg::ST_CNTOF] = cntOf_q;
      statusRd[15:0] = syn_q;
   end

   // record update; misc1 holds the corrected error counter
   always_comb
   begin
      ctl_d = ctl_q;
      addr_d = addr_q;
      misc0_d = misc0_q;
      misc1_d = misc1_q;
      syn_d = syn_q;
      top_d = top_q;
      valid_d = valid_q;
      ceSeen_d = ceSeen_q;
      deSeen_d = deSeen_q;
      ueSeen_d = ueSeen_q;
      of_d = of_q;
      av_d = av_q;
      mv_d = mv_q;
      cntOf_d = cntOf_q;
      fhiPend_d = fhiPend_q;
      recPend_d = recPend_q;
      cntNext = misc1_q + 32'h0000_0001;
      // software writes first, so a same-cycle detection wins
      if (doWrite)
      begin
         if (wAddr_q == err_node_pkg::OFF_CONTROL0)
         begin
            ctl_d = ((wData_q & wMask) | (ctl_q & ~wMask)) & err_node_pkg::CTL_MASK;
         end
         else if (wAddr_q == err_node_pkg::OFF_MISC0)
         begin
            misc0_d = (wData_q & wMask) | (misc0_q & ~wMask);
         end
         else if (wAddr_q == err_node_pkg::OFF_MISC1)
         begin
            misc1_d = (wData_q & wMask) | (misc1_q & ~wMask);
            cntNext = misc1_d + 32'h0000_0001;
         end
         else if (statusWr && wData_q[err_node_pkg::ST_V])
         begin
            // writing one to the valid bit clears the status flags and drops the irqs; syndrome, address and misc0 hold
            valid_d = 1'b0;
            ceSeen_d = 1'b0;
            deSeen_d = 1'b0;
            ueSeen_d = 1'b0;
            of_d = 1'b0;
            av_d = 1'b0;
            mv_d = 1'b0;
            cntOf_d = 1'b0;
            top_d = err_node_pkg::ERR_NONE;
            fhiPend_d = 1'b0;
            recPend_d = 1'b0;
         end
      end
      if (logIt && newKind != err_node_pkg::ERR_NONE)
      begin
         valid_d = 1'b1;
         ceSeen_d = ceSeen_d | (newKind == err_node_pkg::ERR_CE);
         deSeen_d = deSeen_d | (newKind == err_node_pkg::ERR_DE);
         ueSeen_d = ueSeen_d | isUe;
         if (newKind == err_node_pkg::ERR_CE)
         begin
            misc1_d = cntNext;
            if (cntNext == 32'h0000_0000)
            begin
               cntOf_d = 1'b1;
               of_d = 1'b1;
            end
         end
         if (newKind > top_d || !valid_d || top_d == err_node_pkg::ERR_NONE)
         begin
            top_d = newKind;
            syn_d = detect.syndrome;
            av_d = detect.addrValid;
            addr_d = detect.addr;
            misc0_d = detect.unitInfo;
            mv_d = 1'b1;
         end
         else if (newKind != err_node_pkg::ERR_CE)
         begin
            of_d = 1'b1;
         end
         if (newKind == err_node_pkg::ERR_CE ? ctl_q[err_node_pkg::CTL_CIRQ_EN]
                                             : ctl_q[err_node_pkg::CTL_FHI_EN])
         begin
            fhiPend_d = 1'b1;
         end
         if (ctl_q[err_node_pkg::CTL_UIRQ_EN] && (isUe || (newKind == err_node_pkg::ERR_DE
             && ctl_q[err_node_pkg::CTL_DEF_EN])))
         begin
            recPend_d = 1'b1;
         end
      end
      if (logIt && detect.softFault && ctl_q[err_node_pkg::CTL_UIRQ_EN])
      begin
         recPend_d = 1'b1;
      end
   end

   // consumer side: corrected data forwarded, abort only for uncorrected
   always_comb
   begin
      dataOut_d = dataOut_q;
      inband_d = '0;
      if (detect.valid)
      begin
         dataOut_d = (newKind == err_node_pkg::ERR_CE) ? correctedData : dataIn;
         if (isUe && ctl_q[err_node_pkg::CTL_INBAND] && logIt)
         begin
            inband_d.abort = 1'b1;
            inband_d.syndrome = detect.syndrome;
         end
      end
   end

   // axi4-lite slave
   always_comb
   begin
      awHeld_d = awHeld_q;
      wHeld_d = wHeld_q;
      wAddr_d = wAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         awHeld_d = 1'b1;
         wAddr_d = s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (doWrite)
      begin
         awHeld_d = 1'b0;
         wHeld_d = 1'b0;
         bValid_d = 1'b1;
         if (wAddr_q == err_node_pkg::OFF_CONTROL0 || wAddr_q == err_node_pkg::OFF_STATUS0
             || wAddr_q == err_node_pkg::OFF_MISC0 || wAddr_q == err_node_pkg::OFF_MISC1
             || wAddr_q == err_node_pkg::OFF_CONTROL1)
         begin
            bResp_d = err_node_pkg::RESP_OKAY;
         end
         else
         begin
            bResp_d = err_node_pkg::RESP_SLVERR;
         end
      end
      if (bValid_q && s_axi_bready)
      begin
         bValid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         rValid_d = 1'b1;
         rResp_d = err_node_pkg::RESP_OKAY;
         if (s_axi_araddr[11:0] == err_node_pkg::OFF_FEATURE0)
         begin
            rData_d = err_node_pkg::FEATURE_VALUE;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_CONTROL0)
         begin
            rData_d = ctl_q;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_STATUS0)
         begin
            rData_d = statusRd;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_ADDR0)
         begin
            rData_d = addr_q;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_MISC0)
         begin
            rData_d = misc0_q;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_MISC1)
         begin
            rData_d = misc1_q;
         end
         else if (s_axi_araddr[11:0] == err_node_pkg::OFF_FEATURE1
                  || s_axi_araddr[11:0] == err_node_pkg::OFF_CONTROL1)
         begin
            rData_d = 32'h0000_0000;
         end
         else
         begin
            rData_d = 32'h0000_0000;
            rResp_d = err_node_pkg::RESP_SLVERR;
         end
      end
      else if (rValid_q && s_axi_rready)
      begin
         rValid_d = 1'b0;
      end
   end

   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready  = !wHeld_q && !bValid_q;
   assign s_axi_arready = !rValid_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;
   assign dataOut       = dataOut_q;
   assign inband        = inband_q;
   assign faultIrq      = fhiPend_q;
   assign recoveryIrq   = recPend_q;
   assign counterIrq    = cntOf_q && ctl_q[err_node_pkg::CTL_CIRQ_EN];

   // record registers: only power-on reset clears them
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctl_q <= err_node_pkg::CTL_RESET;
         addr_q <= 32'h0000_0000;
         misc0_q <= 32'h0000_0000;
         misc1_q <= 32'h0000_0000;
         syn_q <= 16'h0000;
         top_q <= err_node_pkg::ERR_NONE;
         valid_q <= 1'b0;
         ceSeen_q <= 1'b0;
         deSeen_q <= 1'b0;
         ueSeen_q <= 1'b0;
         of_q <= 1'b0;
         av_q <= 1'b0;
         mv_q <= 1'b0;
         cntOf_q <= 1'b0;
         fhiPend_q <= 1'b0;
         recPend_q <= 1'b0;
      end
      else
      begin
         ctl_q <= ctl_d;
         addr_q <= addr_d;
         misc0_q <= misc0_d;
         misc1_q <= misc1_d;
         syn_q <= syn_d;
         top_q <= top_d;
         valid_q <= valid_d;
         ceSeen_q <= ceSeen_d;
         deSeen_q <= deSeen_d;
         ueSeen_q <= ueSeen_d;
         of_q <= of_d;
         av_q <= av_d;
         mv_q <= mv_d;
         cntOf_q <= cntOf_d;
         fhiPend_q <= fhiPend_d;
         recPend_q <= recPend_d;
      end
   end

   // datapath and bus handshake flags also clear on error-recovery reset; captured bus address, data and responses hold
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dataOut_q <= 32'h0000_0000;
         inband_q <= '0;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         wAddr_q <= 12'h000;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= 2'b00;
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= 2'b00;
      end
      else if (recovery_rst)
      begin
         dataOut_q <= 32'h0000_0000;
         inband_q <= '0;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         bValid_q <= 1'b0;
         rValid_q <= 1'b0;
      end
      else
      begin
         dataOut_q <= dataOut_d;
         inband_q <= inband_d;
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         wAddr_q <= wAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         rValid_q <= rValid_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
      end
   end
endmodule
